// ---- rtl/bsp_pkg.sv ----
// Shared constants for the boot strap and power state controller
package bsp_pkg;

    // Divider ratio is presented as hundredths (0..100)
    localparam int unsigned RATIO_W = 7;

    // Dead battery modes
    typedef enum logic [2:0] {
        DB_NO_RESPONSE  = 3'h0,
        DB_WAIT_SUP_INT = 3'h1,
        DB_WAIT_SUP_EXT = 3'h2,
        DB_HOST_WAIT_INT = 3'h3,
        DB_HOST_WAIT_EXT = 3'h4,
        DB_NO_WAIT      = 3'h5,
        DB_INVALID      = 3'h7
    } bsp_db_mode_t;

    // Fallback default configurations
    typedef enum logic [2:0] {
        DEF_SAFE     = 3'h0,
        DEF_INF_WAIT = 3'h1,
        DEF_ONE      = 3'h2,
        DEF_TWO      = 3'h3,
        DEF_THREE    = 3'h4,
        DEF_FOUR     = 3'h5,
        DEF_FIVE     = 3'h6,
        DEF_RESERVED = 3'h7
    } bsp_def_cfg_t;

    // Run-time power states
    typedef enum logic [1:0] {
        PS_ACTIVE = 2'h0,
        PS_IDLE   = 2'h1,
        PS_SLEEP  = 2'h2
    } bsp_pwr_t;

    // Core clock selector codes
    localparam logic [1:0] CLK_12M  = 2'h0;
    localparam logic [1:0] CLK_IDLE = 2'h1;
    localparam logic [1:0] CLK_100K = 2'h2;

    // Port role codes for default profiles
    localparam logic [1:0] ROLE_OFF = 2'h0;
    localparam logic [1:0] ROLE_DFP = 2'h1;
    localparam logic [1:0] ROLE_UFP = 2'h2;

    // Voltages in volts, currents in tenths of amps
    localparam logic [4:0] V_5   = 5'h05;
    localparam logic [4:0] V_20  = 5'h14;
    localparam logic [4:0] I_0P9 = 5'h09;
    localparam logic [4:0] I_3P0 = 5'h1E;

    // Boot timing: settle time before sampling straps, in ns
    localparam int unsigned STRAP_SETTLE_NS = 1000;
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned STRAP_SETTLE_CYC =
        (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ---- rtl/bsp_strap_decode.sv ----
// Strap level plus divider band decoder
`timescale 1ns/1ps
`default_nettype none
module bsp_strap_decode (
    // Strap inputs
    input  wire logic [6:0]          ratio_i,
    input  wire logic                miso_strap_i,
    // Decoded selection
    output var bsp_pkg::bsp_db_mode_t mode_o,
    output var bsp_pkg::bsp_def_cfg_t def_o
);
    // Band index: tens digit, gaps (x.x9) read as invalid
    wire logic [3:0] band_w  = 4'(ratio_i / 7'd10);
    wire logic       gap_w   = (ratio_i % 7'd10) == 7'd9;
    wire logic       full_w  = ratio_i == 7'd100;

    // Band lookup; ratio exactly 1.00 joins the top band
    always_comb begin
        mode_o = bsp_pkg::DB_INVALID;
        def_o  = bsp_pkg::DEF_SAFE;
        if (full_w || (!gap_w && ratio_i < 7'd100)) begin
            if (miso_strap_i) begin
                case (full_w ? 4'h9 : band_w)
                    4'h0, 4'h1: mode_o = bsp_pkg::DB_NO_RESPONSE;
                    4'h2: mode_o = bsp_pkg::DB_WAIT_SUP_INT;
                    4'h3: begin
                        mode_o = bsp_pkg::DB_HOST_WAIT_INT;
                        def_o  = bsp_pkg::DEF_INF_WAIT;
                    end
                    4'h4: mode_o = bsp_pkg::DB_WAIT_SUP_EXT;
                    4'h5: begin
                        mode_o = bsp_pkg::DB_HOST_WAIT_EXT;
                        def_o  = bsp_pkg::DEF_INF_WAIT;
                    end
                    default: mode_o = bsp_pkg::DB_NO_WAIT;
                endcase
            end else begin
                case (full_w ? 4'h9 : band_w)
                    4'h1: begin
                        mode_o = bsp_pkg::DB_NO_RESPONSE;
                        def_o  = bsp_pkg::DEF_ONE;
                    end
                    4'h2: begin
                        mode_o = bsp_pkg::DB_NO_WAIT;
                        def_o  = bsp_pkg::DEF_TWO;
                    end
                    4'h3: begin
                        mode_o = bsp_pkg::DB_HOST_WAIT_INT;
                        def_o  = bsp_pkg::DEF_INF_WAIT;
                    end
                    4'h4: begin
                        mode_o = bsp_pkg::DB_NO_WAIT;
                        def_o  = bsp_pkg::DEF_THREE;
                    end
                    4'h5: begin
                        mode_o = bsp_pkg::DB_HOST_WAIT_EXT;
                        def_o  = bsp_pkg::DEF_INF_WAIT;
                    end
                    4'h6: begin
                        mode_o = bsp_pkg::DB_NO_WAIT;
                        def_o  = bsp_pkg::DEF_FOUR;
                    end
                    4'h7: begin
                        mode_o = bsp_pkg::DB_NO_WAIT;
                        def_o  = bsp_pkg::DEF_RESERVED;
                    end
                    4'h8: begin
                        mode_o = bsp_pkg::DB_NO_RESPONSE;
                        def_o  = bsp_pkg::DEF_RESERVED;
                    end
                    4'h9: begin
                        mode_o = bsp_pkg::DB_NO_WAIT;
                        def_o  = bsp_pkg::DEF_FIVE;
                    end
                    default: mode_o = bsp_pkg::DB_INVALID;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/bsp_sync2.sv ----
// Two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
`default_nettype none
module bsp_sync2 #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    // Levels
    input  wire logic [W-1:0] d_i,
    output logic [W-1:0]      q_o
);
    // Elaboration check on the width
    if (W < 1) begin : g_bad_w
        $error("W must be at least one");
    end

    logic [W-1:0] meta_q;

    // First stage is read only by the second
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/bsp_ctrl.sv ----
// Boot strap decoder and power state controller top level
`timescale 1ns/1ps
`default_nettype none
module bsp_ctrl #(
    parameter int unsigned SETTLE_CYC = bsp_pkg::STRAP_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Straps and supplies (asynchronous pins)
    input  wire logic       miso_strap_i,
    input  wire logic [6:0] boot_divider_strap_i,
    input  wire logic       main_supply_input_i,
    input  wire logic       vbus_pwr_port_one_i,
    input  wire logic       vbus_pwr_port_two_i,
    // Configuration loader handshake
    output logic            cfg_load_req_o,
    input  wire logic       cfg_load_done_i,
    input  wire logic       cfg_load_ok_i,
    input  wire logic [1:0] cfg_loaded_sw_i,
    input  wire logic       cfg_loaded_ext_i,
    // Power state requests and events
    input  wire logic       idle_req_i,
    input  wire logic       sleep_req_i,
    input  wire logic       connected_i,
    input  wire logic       attach_evt_i,
    input  wire logic       pd_msg_evt_i,
    input  wire logic       i2c_evt_i,
    // Boot status
    output logic [2:0]      dead_batt_mode_o,
    output logic [2:0]      default_cfg_o,
    output logic            boot_done_o,
    output logic            using_default_o,
    // Power path
    output logic [1:0]      int_switch_en_o,
    output logic [1:0]      ext_switch_en_o,
    output logic            ext_path_ctrl_port_one_o,
    output logic            ext_path_ctrl_port_two_o,
    output logic            sink_only_o,
    // Default profile
    output logic [1:0]      port_role_o,
    output logic [4:0]      sink_vmin_o,
    output logic [4:0]      sink_vmax_o,
    output logic [4:0]      sink_imin_o,
    output logic [4:0]      sink_imax_o,
    output logic [4:0]      src_volt_o,
    output logic [4:0]      src_curr_o,
    output logic            alt_modes_en_o,
    // Power state outputs
    output logic [1:0]      pwr_state_o,
    output logic [1:0]      core_clk_sel_o,
    output logic            osc_24m_en_o,
    output logic            osc_100k_en_o,
    output logic            pd_en_o,
    output logic            i2c_en_o,
    output logic            spi_en_o,
    output logic            pd_msg_accept_o
);
    // Elaboration check on the settle count
    if (SETTLE_CYC < 1 || SETTLE_CYC > 4096) begin : g_bad_settle
        $error("SETTLE_CYC out of range");
    end

    // Boot states
    typedef enum logic [2:0] {
        BS_SETTLE = 3'h0,
        BS_SAMPLE = 3'h1,
        BS_HOLD   = 3'h2,
        BS_LOAD   = 3'h3,
        BS_WAITLD = 3'h4,
        BS_RUN    = 3'h5,
        BS_WAIT   = 3'h6
    } bsp_boot_t;

    // Synchronised pins; the ratio word is static while straps settle, so no gray code
    logic [10:0] sync_w;
    bsp_sync2 #(.W(11)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .d_i       ({miso_strap_i, boot_divider_strap_i, main_supply_input_i,
                     vbus_pwr_port_two_i, vbus_pwr_port_one_i}),
        .q_o       (sync_w)
    );
    wire logic       strap_s  = sync_w[10];
    wire logic [6:0] ratio_s  = sync_w[9:3];
    wire logic       supply_s = sync_w[2];
    // Bit 0 is port one, matching the per-port switch vectors
    wire logic [1:0] vbus_s   = sync_w[1:0];

    // Combinational decode of the live straps
    bsp_pkg::bsp_db_mode_t mode_w;
    bsp_pkg::bsp_def_cfg_t def_w;
    bsp_strap_decode u_dec (
        .ratio_i      (ratio_s),
        .miso_strap_i (strap_s),
        .mode_o       (mode_w),
        .def_o        (def_w)
    );

    // Boot registers
    bsp_boot_t             boot_q, boot_d;
    bsp_pkg::bsp_db_mode_t mode_q;
    bsp_pkg::bsp_def_cfg_t def_q;
    logic [12:0]           cnt_q;
    logic                  loaded_q;
    logic [1:0]            ld_sw_q;
    logic                  ld_ext_q;
    logic [1:0]            rx_port_q;

    // Derived mode classes
    wire logic m_noresp = mode_q == bsp_pkg::DB_NO_RESPONSE || mode_q == bsp_pkg::DB_INVALID;
    wire logic m_wsup   = mode_q == bsp_pkg::DB_WAIT_SUP_INT || mode_q == bsp_pkg::DB_WAIT_SUP_EXT;
    wire logic m_host   = mode_q == bsp_pkg::DB_HOST_WAIT_INT || mode_q == bsp_pkg::DB_HOST_WAIT_EXT;
    wire logic m_ext    = mode_q == bsp_pkg::DB_WAIT_SUP_EXT || mode_q == bsp_pkg::DB_HOST_WAIT_EXT;
    wire logic on_vbus  = !supply_s;
    // Endless retry when host-wait, or infinite-wait default is strapped
    wire logic retry_w  = m_host || def_q == bsp_pkg::DEF_INF_WAIT;

    // Boot sequence next state
    always_comb begin
        boot_d = boot_q;
        case (boot_q)
            BS_SETTLE: if (cnt_q == 13'(SETTLE_CYC - 1)) boot_d = BS_SAMPLE;
            BS_SAMPLE: boot_d = BS_HOLD;
            BS_HOLD: begin
                // No-response and wait-supply hold while off the main supply
                if (!(on_vbus && (m_noresp || m_wsup))) boot_d = BS_LOAD;
            end
            BS_LOAD: boot_d = BS_WAITLD;
            BS_WAITLD: begin
                if (cfg_load_done_i) begin
                    if (cfg_load_ok_i) boot_d = BS_RUN;
                    else if (retry_w) boot_d = BS_LOAD;
                    else boot_d = BS_RUN;
                end
            end
            BS_RUN: boot_d = BS_RUN;
            default: boot_d = BS_SETTLE;
        endcase
    end

    // Boot registers; straps captured only in the sample state
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            boot_q    <= BS_SETTLE;
            cnt_q     <= 13'h0000;
            mode_q    <= bsp_pkg::DB_NO_RESPONSE;
            def_q     <= bsp_pkg::DEF_SAFE;
            loaded_q  <= 1'b0;
            ld_sw_q   <= 2'h0;
            ld_ext_q  <= 1'b0;
            rx_port_q <= 2'h0;
        end else begin
            boot_q <= boot_d;
            cnt_q  <= (boot_q == BS_SETTLE) ? cnt_q + 13'h0001 : 13'h0000;
            if (boot_q == BS_SAMPLE) begin
                mode_q    <= mode_w;
                def_q     <= def_w;
                rx_port_q <= vbus_s[0] ? 2'h1 : (vbus_s[1] ? 2'h2 : 2'h0);
            end
            if (boot_q == BS_WAITLD && cfg_load_done_i && cfg_load_ok_i) begin
                loaded_q <= 1'b1;
                ld_sw_q  <= cfg_loaded_sw_i;
                ld_ext_q <= cfg_loaded_ext_i;
            end
        end
    end

    // Power switch selection
    wire logic past_sample = boot_q != BS_SETTLE && boot_q != BS_SAMPLE;
    wire logic early_close = past_sample && on_vbus && (m_wsup || m_host);
    wire logic [1:0] early_w = early_close ? rx_port_q : 2'h0;
    wire logic [1:0] cfg_sw_w = (loaded_q && boot_q == BS_RUN) ? ld_sw_q : 2'h0;
    wire logic def_run = boot_q == BS_RUN && !loaded_q;
    wire logic def_ext = def_q == bsp_pkg::DEF_FOUR || def_q == bsp_pkg::DEF_FIVE;
    wire logic def_int_on = def_run && (def_q == bsp_pkg::DEF_ONE || def_q == bsp_pkg::DEF_TWO
                             || def_q == bsp_pkg::DEF_THREE);
    wire logic safe_sink = def_run && def_q == bsp_pkg::DEF_SAFE && on_vbus;
    wire logic [1:0] safe_w = safe_sink ? rx_port_q : 2'h0;
    wire logic [1:0] def_int_w = def_int_on ? 2'h3 : 2'h0;
    wire logic [1:0] def_ext_w = (def_run && def_ext) ? 2'h3 : 2'h0;

    // Switch outputs; no-response on bus power (main supply absent) keeps all open
    always_comb begin
        int_switch_en_o = 2'h0;
        ext_switch_en_o = 2'h0;
        if (!(m_noresp && on_vbus)) begin
            int_switch_en_o = (m_ext ? 2'h0 : early_w) | (ld_ext_q ? 2'h0 : cfg_sw_w) | def_int_w | safe_w;
            ext_switch_en_o = (m_ext ? early_w : 2'h0) | (ld_ext_q ? cfg_sw_w : 2'h0) | def_ext_w;
        end
    end
    assign ext_path_ctrl_port_one_o = ext_switch_en_o[0];
    assign ext_path_ctrl_port_two_o = ext_switch_en_o[1];
    assign sink_only_o = on_vbus;

    // Boot status
    assign cfg_load_req_o   = boot_q == BS_LOAD;
    assign dead_batt_mode_o = mode_q;
    assign default_cfg_o    = def_q;
    assign boot_done_o      = boot_q == BS_RUN;
    assign using_default_o  = def_run;

    // Default profile table
    always_comb begin
        port_role_o    = bsp_pkg::ROLE_OFF;
        sink_vmin_o    = 5'h00;
        sink_vmax_o    = 5'h00;
        sink_imin_o    = 5'h00;
        sink_imax_o    = 5'h00;
        src_volt_o     = 5'h00;
        src_curr_o     = 5'h00;
        alt_modes_en_o = 1'b0;  // Every default disables alternate modes
        if (def_run) begin
            case (def_q)
                bsp_pkg::DEF_SAFE: if (on_vbus) begin
                    port_role_o = bsp_pkg::ROLE_UFP;
                    sink_vmin_o = bsp_pkg::V_5;
                    sink_vmax_o = bsp_pkg::V_5;
                end
                bsp_pkg::DEF_ONE: begin
                    port_role_o = bsp_pkg::ROLE_DFP;
                    src_volt_o  = bsp_pkg::V_5;
                    src_curr_o  = bsp_pkg::I_3P0;
                end
                bsp_pkg::DEF_TWO, bsp_pkg::DEF_THREE,
                bsp_pkg::DEF_FOUR, bsp_pkg::DEF_FIVE: begin
                    port_role_o = bsp_pkg::ROLE_UFP;
                    sink_vmin_o = bsp_pkg::V_5;
                    sink_vmax_o = (def_q == bsp_pkg::DEF_THREE || def_q == bsp_pkg::DEF_FIVE)
                                  ? bsp_pkg::V_20 : bsp_pkg::V_5;
                    sink_imin_o = bsp_pkg::I_0P9;
                    sink_imax_o = bsp_pkg::I_3P0;
                    src_volt_o  = def_ext ? bsp_pkg::V_5 : 5'h00;
                    src_curr_o  = def_ext ? bsp_pkg::I_3P0 : 5'h00;
                end
                default: port_role_o = bsp_pkg::ROLE_OFF;
            endcase
        end
        // Bus-derived regulator strips any source capability
        if (on_vbus) begin
            src_volt_o = 5'h00;
            src_curr_o = 5'h00;
            if (port_role_o == bsp_pkg::ROLE_DFP) port_role_o = bsp_pkg::ROLE_OFF;
        end
    end

    // Power state machine
    bsp_pkg::bsp_pwr_t ps_q, ps_d;
    logic              drop_q;
    wire logic wake_idle  = attach_evt_i || pd_msg_evt_i || i2c_evt_i;
    wire logic wake_sleep = attach_evt_i || i2c_evt_i;

    always_comb begin
        ps_d = ps_q;
        case (ps_q)
            bsp_pkg::PS_ACTIVE: begin
                if (sleep_req_i && !connected_i) ps_d = bsp_pkg::PS_SLEEP;
                else if (idle_req_i) ps_d = bsp_pkg::PS_IDLE;
            end
            bsp_pkg::PS_IDLE: begin
                if (wake_idle) ps_d = bsp_pkg::PS_ACTIVE;
                else if (sleep_req_i && !connected_i) ps_d = bsp_pkg::PS_SLEEP;
            end
            bsp_pkg::PS_SLEEP: begin
                if (wake_sleep || connected_i) ps_d = bsp_pkg::PS_ACTIVE;
            end
            default: ps_d = bsp_pkg::PS_ACTIVE;
        endcase
    end

    // State register and discard flag for the waking message
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ps_q   <= bsp_pkg::PS_ACTIVE;
            drop_q <= 1'b0;
        end else begin
            ps_q   <= (boot_q == BS_RUN) ? ps_d : bsp_pkg::PS_ACTIVE;
            drop_q <= ps_q == bsp_pkg::PS_IDLE && pd_msg_evt_i;
        end
    end

    // Per-state clocks and feature gating
    assign pwr_state_o     = ps_q;
    assign core_clk_sel_o  = ps_q == bsp_pkg::PS_ACTIVE ? bsp_pkg::CLK_12M :
                             (ps_q == bsp_pkg::PS_IDLE ? bsp_pkg::CLK_IDLE : bsp_pkg::CLK_100K);
    assign osc_24m_en_o    = ps_q != bsp_pkg::PS_SLEEP;
    assign osc_100k_en_o   = 1'b1;
    assign pd_en_o         = ps_q == bsp_pkg::PS_ACTIVE;
    assign spi_en_o        = ps_q == bsp_pkg::PS_ACTIVE;
    assign i2c_en_o        = ps_q != bsp_pkg::PS_SLEEP;
    // Message that caused the wake is not passed on
    assign pd_msg_accept_o = pd_en_o && pd_msg_evt_i && !drop_q && ps_q == bsp_pkg::PS_ACTIVE;

    // Checks; a message seen while idle is the first step of a wake
    sequence seq_idle_msg;
        ps_q == bsp_pkg::PS_IDLE && pd_msg_evt_i;
    endsequence

    chk_sleep_unconn: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ps_q == bsp_pkg::PS_SLEEP |-> !$past(connected_i))
        else $error("sleep entered while connected");
    chk_osc_sleep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        osc_100k_en_o && osc_24m_en_o == (pwr_state_o != bsp_pkg::PS_SLEEP))
        else $error("oscillator enables wrong for state");
    chk_noresp_open: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        m_noresp && on_vbus |-> int_switch_en_o == 2'h0 && ext_switch_en_o == 2'h0)
        else $error("switch closed in no-response mode");
    chk_wsup_noload: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        boot_q == BS_HOLD && m_wsup && on_vbus |=> !cfg_load_req_o)
        else $error("load attempted without main supply");
    chk_host_retry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        boot_q == BS_WAITLD && cfg_load_done_i && !cfg_load_ok_i && m_host |=> cfg_load_req_o)
        else $error("host-wait did not retry load");
    chk_sleep_wake: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ps_q == bsp_pkg::PS_SLEEP && boot_q == BS_RUN && i2c_evt_i |=> ps_q == bsp_pkg::PS_ACTIVE)
        else $error("no wake from sleep on bus traffic");
    chk_pd_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        seq_idle_msg ##1 pd_msg_evt_i |-> !pd_msg_accept_o)
        else $error("waking message was accepted");
    chk_sink_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        on_vbus |-> src_volt_o == 5'h00 && port_role_o != bsp_pkg::ROLE_DFP)
        else $error("source offered on bus power");
    chk_strap_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        boot_q != BS_SAMPLE && boot_q != BS_SETTLE ##1 1'b1 |-> $stable(mode_q))
        else $error("strap mode changed after sampling");
    chk_ext_pins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        {ext_path_ctrl_port_two_o, ext_path_ctrl_port_one_o} == ext_switch_en_o)
        else $error("external path pin mismatch");
endmodule
`default_nettype wire

// ---- verification/bsp_loader_model.sv ----
// Configuration loader model answering load requests
`timescale 1ns/1ps
`default_nettype none
module bsp_loader_model (
    // Clock, reset and handshake
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire logic       fail_i,
    output logic            done_o,
    output logic            ok_o,
    output logic [1:0]      sw_o
);
    logic [2:0] cnt_q;
    // Answer four cycles after a request; qualifiers wander outside done
    always_ff @(posedge ref_clk_i) begin
        cnt_q  <= rst_i ? 3'h0 : (req_i ? 3'h3 : (cnt_q != 3'h0 ? cnt_q - 3'h1 : 3'h0));
        done_o <= !rst_i && cnt_q == 3'h1;
        ok_o   <= (cnt_q == 3'h1) ? !fail_i : (cnt_q != 3'h0);
        sw_o   <= rst_i ? 2'h2 : ((cnt_q == 3'h1) ? 2'h1 : ~sw_o);
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the strap decoder and power state controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, miso = 1'b0, sup = 1'b1, vb1 = 1'b0, req, done, ok;
    logic idle = 1'b0, slp = 1'b0, con = 1'b1, pd = 1'b0, i2c = 1'b0, bd, acc, s24, s100, pde, i2e;
    logic [6:0] ratio = 7'h00;
    logic vb2 = 1'b0, fail = 1'b0, lext = 1'b0, att = 1'b0, udef, e2, spe, alt;
    logic [4:0] sv, sc, svx;
    logic [1:0] sw, isw, esw, pst, csel, role;
    logic [2:0] mode, dcfg;
    logic e1, sko;
    int err_count = 0, n_tests = 0, cyc = 0;
    logic [13:0] tbl [13] = '{{1'h1,7'h32,3'h4,3'h1}, {1'h1,7'h3C,3'h5,3'h0}, {1'h0,7'h0A,3'h0,3'h2},
        {1'h0,7'h1C,3'h5,3'h3}, {1'h0,7'h1E,3'h3,3'h1}, {1'h0,7'h30,3'h5,3'h4}, {1'h0,7'h44,3'h5,3'h5},
        {1'h0,7'h46,3'h5,3'h7}, {1'h0,7'h58,3'h0,3'h7}, {1'h0,7'h64,3'h5,3'h6}, {1'h1,7'h00,3'h0,3'h0},
        {1'h1,7'h14,3'h1,3'h0}, {1'h1,7'h28,3'h2,3'h0}};
    // Half period of the 40 MHz clock
    always #12.5 clk = ~clk;
    bsp_ctrl #(.SETTLE_CYC(2)) dut_u (.ref_clk_i(clk), .rst_i(rst), .miso_strap_i(miso),
        .boot_divider_strap_i(ratio), .main_supply_input_i(sup), .vbus_pwr_port_one_i(vb1),
        .vbus_pwr_port_two_i(vb2), .cfg_load_req_o(req), .cfg_load_done_i(done), .cfg_load_ok_i(ok),
        .cfg_loaded_sw_i(sw), .cfg_loaded_ext_i(lext), .idle_req_i(idle), .sleep_req_i(slp),
        .connected_i(con), .attach_evt_i(att), .pd_msg_evt_i(pd), .i2c_evt_i(i2c),
        .dead_batt_mode_o(mode), .default_cfg_o(dcfg), .boot_done_o(bd), .using_default_o(udef),
        .int_switch_en_o(isw), .ext_switch_en_o(esw), .ext_path_ctrl_port_one_o(e1),
        .ext_path_ctrl_port_two_o(e2), .sink_only_o(sko), .port_role_o(role), .sink_vmin_o(),
        .sink_vmax_o(svx), .sink_imin_o(), .sink_imax_o(), .src_volt_o(sv), .src_curr_o(sc),
        .alt_modes_en_o(alt), .pwr_state_o(pst), .core_clk_sel_o(csel), .osc_24m_en_o(s24),
        .osc_100k_en_o(s100), .pd_en_o(pde), .i2c_en_o(i2e), .spi_en_o(spe), .pd_msg_accept_o(acc));
    bsp_loader_model loader_u (.ref_clk_i(clk), .rst_i(rst), .req_i(req), .fail_i(fail), .done_o(done),
        .ok_o(ok), .sw_o(sw));
    task automatic end_of_test();
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // Straps are set under reset, then the boot is given time to settle
    task automatic boot(input logic m, input logic [6:0] r, input logic s, input logic [1:0] v);
        @(negedge clk);
        {miso, ratio, sup, vb2, vb1, rst} = {m, r, s, v, 1'b1};
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Hang guard
    always @(posedge clk) if (++cyc > 5000) begin
        err_count++;
        end_of_test();
    end
    initial begin
        foreach (tbl[i]) begin
            boot(tbl[i][13], tbl[i][12:6], 1'b1, 2'h0);
            check("mode", mode, tbl[i][5:3]);
            check("dflt", dcfg, tbl[i][2:0]);
        end
        boot(1'b1, 7'h0A, 1'b0, 2'h1);
        check("noresp", {bd, isw, esw}, 8'h00);
        check("sink", sko, 8'h01);
        boot(1'b1, 7'h28, 1'b0, 2'h1);
        check("extwait", {bd, e1, esw[0]}, 8'h03);
        boot(1'b1, 7'h28, 1'b0, 2'h2);
        check("extwait2", {e2, esw}, 8'h06);
        // Failing loader: defaults apply unless a wait mode retries
        fail = 1'b1;
        boot(1'b1, 7'h3C, 1'b0, 2'h1);
        check("safe", {bd, udef, isw}, 8'h0D);
        check("saferole", role, 8'h02);
        check("safev", svx, 8'h05);
        boot(1'b0, 7'h0A, 1'b1, 2'h0);
        check("def1", {role, sv}, 8'h25);
        check("def1cur", {alt, sc}, 8'h1E);
        boot(1'b1, 7'h32, 1'b0, 2'h1);
        check("hostwait", {bd, isw, esw}, 8'h01);
        {fail, lext} = 2'b01;
        step(14);
        check("retry", bd, 8'h01);
        check("cfgext", {isw, esw}, 8'h01);
        lext = 1'b0;
        boot(1'b0, 7'h1C, 1'b1, 2'h0);
        check("booted", bd, 8'h01);
        check("cfgsw", {isw, esw}, 8'h04);
        idle = 1'b1;
        step(3);
        idle = 1'b0;
        check("idle", {pst, csel, s24, s100, pde, i2e}, 8'h5D);
        pd = 1'b1;
        #1 check("idlemsg", acc, 8'h00);
        step(1);
        check("drop", acc, 8'h00);
        check("wake", pst, 8'h00);
        step(1);
        check("accept", acc, 8'h01);
        pd = 1'b0;
        con = 1'b0;
        slp = 1'b1;
        step(3);
        slp = 1'b0;
        check("sleep", {pst, csel, s24, s100, i2e, spe}, 8'hA4);
        pd = 1'b1;
        step(1);
        check("pdnowake", pst, 8'h02);
        {pd, i2c} = 2'b01;
        step(1);
        i2c = 1'b0;
        check("i2cwake", pst, 8'h00);
        idle = 1'b1;
        step(1);
        {idle, att} = 2'b01;
        step(1);
        att = 1'b0;
        check("attwake", pst, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
